// ---- mhc_pkg.sv ----
/*
  Shared constants for the maintenance hours counter: time base, field
  widths and limits, register offsets and field positions, reset values.
  Assumes a 25 MHz core clock and an APB register bus with 32-bit data.
*/
package mhc_pkg;
  // time base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MINUTE_S = 60;
  localparam int unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  localparam int unsigned MIN_PER_H = 60;

  // field widths and limits
  localparam int PER_HW = 14;
  localparam int RUN_HW = 17;
  localparam int MIN_W = 6;
  localparam int TOT_W = 23;
  localparam logic [PER_HW-1:0] PER_H_MAX = 14'h270f;
  localparam logic [RUN_HW-1:0] RUN_H_MAX = 17'h1869f;
  localparam logic [MIN_W-1:0] MIN_MAX = 6'h3b;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RUN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REMAIN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

  // field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_CFG_BIT = 2;
  localparam int HRS_LSB = 0;
  localparam int MIN_LSB = 24;
  localparam int STAT_ALARM_BIT = 0;
  localparam int STAT_SAT_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [PER_HW-1:0] PER_H_RST = 14'h0000;
  localparam logic [RUN_HW-1:0] RUN_H_RST = 17'h00000;
  localparam logic [MIN_W-1:0] MIN_RST = 6'h00;

  typedef enum logic {MHC_CLR_RESET, MHC_CLR_RESET_IDLE} mhc_clear_e;
endpackage

// ---- mhc_divider.sv ----
/*
  Iterative restoring divider: quotient and remainder of two unsigned
  words, one bit per enabled cycle. Assumes the caller never starts it
  with a zero divisor and holds no operand: they are latched at start.
*/
`timescale 1ns/1ps
module mhc_divider #(
  parameter int W = 23
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0] quo_q, rem_q, div_q;
  logic [CW-1:0] cnt_q;
  logic busy_q, done_q;
  logic [W:0] shifted, trial;

  assign shifted = {rem_q, quo_q[W-1]};
  assign trial = shifted - {1'b0, div_q};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      quo_q <= '0;
      rem_q <= '0;
      div_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (start) begin
        quo_q <= dividend;
        rem_q <= '0;
        div_q <= divisor;
        cnt_q <= CW'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        // negative trial means the divisor did not fit: keep the shift
        rem_q <= trial[W] ? shifted[W-1:0] : trial[W-1:0];
        quo_q <= {quo_q[W-2:0], ~trial[W]};
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign quotient = quo_q;
  assign remainder = rem_q;
  assign busy = busy_q;
  assign done = done_q;
endmodule

// ---- mhc_maint_counter.sv ----
/*
  Maintenance hours counter with an APB register slave. Counts on-time of
  the monitored enable, counts down the remaining service time, raises the
  alarm at zero. Assumes enable/reset/clear inputs and the external period
  come from control logic on core_clk; porRst is the power-on reset of the
  retained values, rst the warm reset of everything else.
*/
//
// What this block does
// (R1) partial reset rising edge clears alarm and reloads remaining time from period
// (R2) partial reset never touches accumulated run hours
// (R3) full clear rising edge clears alarm, zeroes run hours, reloads remaining time
// (R4) while enable is high outside config mode, run time grows and remaining time shrinks
// (R5) alarm rises once remaining time is zero
// (R6) reset-only mode: alarm low whenever partial reset or full clear is high
// (R7) reset-or-idle mode: alarm also low whenever enable is low
// (R8) period, remaining time and run hours survive warm reset
// (R9) period held as hours 0..9999 plus minutes 0..59
// (R10) run hours saturate at 99999, minutes 0..59
// (R11) run hours keep counting during partial reset
// (R12) run hours preset in config: remaining = period - (run mod period)
// (R13) no run preset in operation; period change reloads remaining directly
// (R14) external period value is whole hours only
// (R15) edges found against last cycle; remaining drops once a minute, holds at zero
`timescale 1ns/1ps
module mhc_maint_counter #(
  parameter int unsigned MINUTE_TICKS = mhc_pkg::MINUTE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic porRst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mhc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enableIn,
  input wire logic partialResetIn,
  input wire logic fullClearIn,
  input wire logic [mhc_pkg::PER_HW-1:0] extPeriodHours,
  output logic alarmOut
);
  import mhc_pkg::*;

  typedef enum logic [1:0] {MHC_IDLE, MHC_MODP, MHC_TOHM} mhc_pre_e;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == OFF_CTRL || a == OFF_PERIOD || a == OFF_RUN || a == OFF_REMAIN || a == OFF_STATUS;
  endfunction

  function automatic logic [TOT_W-1:0] toTot(input logic [RUN_HW-1:0] h, input logic [MIN_W-1:0] m);
    return TOT_W'(h) * TOT_W'(MIN_PER_H) + TOT_W'(m);
  endfunction

  function automatic logic [MIN_W-1:0] clampM(input logic [MIN_W-1:0] m);
    return (m > MIN_MAX) ? MIN_MAX : m;
  endfunction

  function automatic logic [PER_HW-1:0] clampPH(input logic [PER_HW-1:0] h);
    return (h > PER_H_MAX) ? PER_H_MAX : h;
  endfunction

  mhc_clear_e mode_q;
  logic useExt_q, cfg_q;
  logic enPrev_q, rstPrev_q, clrPrev_q;
  logic [31:0] tickCnt_q;
  logic [PER_HW-1:0] perH_q, prevEffH_q, effH;
  logic [MIN_W-1:0] perM_q, prevEffM_q, effM;
  logic [RUN_HW-1:0] runH_q, wrRunH;
  logic [MIN_W-1:0] runM_q, wrRunM;
  logic [PER_HW-1:0] remH_q;
  logic [MIN_W-1:0] remM_q;
  logic alarm_q;
  logic [31:0] prdata_q, rdVal;
  mhc_pre_e preSt_q;
  logic live, access, wrEn, riseR, riseClr, tick, remZero, periodChg, clrCond;
  logic runPresetWr, preGo, preDone, divStart, divBusy, divDone;
  logic [TOT_W-1:0] perTot, divA, divB, divQ, divR;

  assign live = ce & ~rst;
  assign access = psel & penable;
  assign wrEn = access & pwrite & ce;
  assign pready = ce;
  assign pslverr = access & ~isMapped(paddr);

  // edges are the current input against its value one cycle earlier
  assign riseR = partialResetIn & ~rstPrev_q; // R15
  assign riseClr = fullClearIn & ~clrPrev_q; // R15

  // external source carries hours only, no minutes part
  assign effH = useExt_q ? clampPH(extPeriodHours) : perH_q; // R14
  assign effM = useExt_q ? MIN_RST : perM_q; // R14
  assign perTot = toTot(RUN_HW'(effH), effM);
  assign periodChg = (effH != prevEffH_q) || (effM != prevEffM_q);
  assign remZero = (remH_q == '0) && (remM_q == '0);

  // counting is suspended in config mode, like a stopped program
  assign tick = live & enableIn & ~cfg_q & (tickCnt_q == 32'(MINUTE_TICKS - 1)); // R4

  assign wrRunH = (RUN_HW'(pwdata[HRS_LSB +: RUN_HW]) > RUN_H_MAX) ? RUN_H_MAX : pwdata[HRS_LSB +: RUN_HW];
  assign wrRunM = clampM(pwdata[MIN_LSB +: MIN_W]);
  assign runPresetWr = wrEn & ~rst & cfg_q & (paddr == OFF_RUN) & (preSt_q == MHC_IDLE); // R13
  assign preGo = runPresetWr & (perTot != '0);

  // two divisions share one divider: run mod period, then minutes to h:m
  assign divStart = ce & ((preSt_q == MHC_IDLE && preGo) || (preSt_q == MHC_MODP && divDone));
  assign divA = (preSt_q == MHC_IDLE) ? toTot(wrRunH, wrRunM) : perTot - divR; // R12
  assign divB = (preSt_q == MHC_IDLE) ? perTot : TOT_W'(MIN_PER_H);
  assign preDone = ce & (preSt_q == MHC_TOHM) & divDone;

  mhc_divider #(.W(TOT_W)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .start(divStart),
    .dividend(divA),
    .divisor(divB),
    .quotient(divQ),
    .remainder(divR),
    .busy(divBusy),
    .done(divDone)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      preSt_q <= MHC_IDLE;
    end else if (ce) begin
      unique case (preSt_q)
        MHC_IDLE: if (preGo) preSt_q <= MHC_MODP;
        MHC_MODP: if (divDone) preSt_q <= MHC_TOHM;
        MHC_TOHM: if (divDone) preSt_q <= MHC_IDLE;
        default: preSt_q <= MHC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enPrev_q <= 1'b0;
      rstPrev_q <= 1'b0;
      clrPrev_q <= 1'b0;
    end else if (ce) begin
      enPrev_q <= enableIn;
      rstPrev_q <= partialResetIn; // R15
      clrPrev_q <= fullClearIn; // R15
    end
  end

  // partial minutes carry over between on-periods of the enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tickCnt_q <= '0;
    end else if (ce && enableIn && !cfg_q) begin
      tickCnt_q <= tick ? '0 : tickCnt_q + 32'h1; // R4
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= MHC_CLR_RESET;
      useExt_q <= CTRL_RST;
      cfg_q <= CTRL_RST;
    end else if (wrEn && paddr == OFF_CTRL) begin
      mode_q <= pwdata[CTRL_MODE_BIT] ? MHC_CLR_RESET_IDLE : MHC_CLR_RESET;
      useExt_q <= pwdata[CTRL_EXT_BIT];
      cfg_q <= pwdata[CTRL_CFG_BIT];
    end
  end

  // retained values: only the power-on reset clears them
  always_ff @(posedge core_clk or posedge porRst) begin
    if (porRst) begin
      perH_q <= PER_H_RST;
      perM_q <= MIN_RST;
    end else if (wrEn && !rst && paddr == OFF_PERIOD) begin // R8
      perH_q <= clampPH(pwdata[HRS_LSB +: PER_HW]); // R9
      perM_q <= clampM(pwdata[MIN_LSB +: MIN_W]); // R9
    end
  end

  always_ff @(posedge core_clk or posedge porRst) begin
    if (porRst) begin
      prevEffH_q <= PER_H_RST;
      prevEffM_q <= MIN_RST;
    end else if (live) begin
      prevEffH_q <= effH;
      prevEffM_q <= effM;
    end
  end

  always_ff @(posedge core_clk or posedge porRst) begin
    if (porRst) begin
      runH_q <= RUN_H_RST;
      runM_q <= MIN_RST;
    end else if (live) begin
      if (riseClr) begin
        runH_q <= RUN_H_RST; // R3
        runM_q <= MIN_RST; // R3
      end else if (runPresetWr) begin
        runH_q <= wrRunH; // R12
        runM_q <= wrRunM;
      end else if (tick && runH_q != RUN_H_MAX) begin // R2
        // partial reset is deliberately not looked at here
        if (runM_q == MIN_MAX) begin // R11
          runM_q <= MIN_RST;
          runH_q <= runH_q + RUN_HW'(1); // R10
        end else begin
          runM_q <= runM_q + MIN_W'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge porRst) begin
    if (porRst) begin
      remH_q <= PER_H_RST;
      remM_q <= MIN_RST;
    end else if (live) begin
      if (riseClr || riseR) begin
        remH_q <= effH; // R1 R3
        remM_q <= effM;
      end else if (periodChg) begin
        remH_q <= effH; // R13
        remM_q <= effM;
      end else if (runPresetWr && !preGo) begin
        remH_q <= PER_H_RST;
        remM_q <= MIN_RST;
      end else if (preDone) begin
        remH_q <= PER_HW'(divQ); // R12
        remM_q <= MIN_W'(divR);
      end else if (tick && !remZero) begin
        if (remM_q == '0) begin // R15
          remM_q <= MIN_MAX;
          remH_q <= remH_q - PER_HW'(1);
        end else begin
          remM_q <= remM_q - MIN_W'(1); // R4
        end
      end
    end
  end

  // clearing outranks setting: a held reset keeps the alarm low at zero
  assign clrCond = partialResetIn | fullClearIn | ((mode_q == MHC_CLR_RESET_IDLE) & ~enableIn); // R6 R7

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_q <= 1'b0;
    end else if (ce) begin
      if (clrCond) begin
        alarm_q <= 1'b0; // R1 R3 R6 R7
      end else if (remZero) begin
        alarm_q <= 1'b1; // R5
      end
    end
  end
  assign alarmOut = alarm_q;

  always_comb begin
    rdVal = '0;
    unique case (paddr)
      OFF_CTRL: begin
        rdVal[CTRL_MODE_BIT] = (mode_q == MHC_CLR_RESET_IDLE);
        rdVal[CTRL_EXT_BIT] = useExt_q;
        rdVal[CTRL_CFG_BIT] = cfg_q;
      end
      OFF_PERIOD: begin
        rdVal[HRS_LSB +: PER_HW] = perH_q;
        rdVal[MIN_LSB +: MIN_W] = perM_q;
      end
      OFF_RUN: begin
        rdVal[HRS_LSB +: RUN_HW] = runH_q;
        rdVal[MIN_LSB +: MIN_W] = runM_q;
      end
      OFF_REMAIN: begin
        rdVal[HRS_LSB +: PER_HW] = remH_q;
        rdVal[MIN_LSB +: MIN_W] = remM_q;
      end
      OFF_STATUS: begin
        rdVal[STAT_ALARM_BIT] = alarm_q;
        rdVal[STAT_SAT_BIT] = (runH_q == RUN_H_MAX);
        rdVal[STAT_BUSY_BIT] = (preSt_q != MHC_IDLE) | divBusy;
      end
      default: rdVal = '0;
    endcase
  end

  // read data captured in the setup phase, stable through the access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (ce && psel && !penable) begin
      prdata_q <= rdVal;
    end
  end
  assign prdata = prdata_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || porRst);

  a_partial_reload: assert property (ce && !rst && riseR && !riseClr |=> // R1
    remH_q == $past(effH) && remM_q == $past(effM)) else $error("partial reset did not reload");
  a_partial_keeps_run: assert property (live && riseR && !riseClr && !tick && !runPresetWr |=> // R2
    $stable(runH_q) && $stable(runM_q)) else $error("partial reset changed run hours");
  a_full_clear: assert property (live && riseClr |=> runH_q == '0 && runM_q == '0 // R3
    && !alarmOut && remH_q == $past(effH)) else $error("full clear incomplete");
  a_minute_step: assert property (tick && !remZero && !riseR && !riseClr && !periodChg && !runPresetWr // R4
    && !preDone |=> toTot(RUN_HW'(remH_q), remM_q) == $past(toTot(RUN_HW'(remH_q), remM_q)) - TOT_W'(1))
    else $error("remaining time did not drop by one minute");
  a_alarm_sets: assert property (ce && remZero && !clrCond |=> alarmOut) // R5
    else $error("alarm missing at zero");
  a_reset_clears: assert property (ce && (partialResetIn || fullClearIn) |=> !alarmOut) // R6
    else $error("alarm not cleared by reset input");
  a_idle_clears: assert property (ce && mode_q == MHC_CLR_RESET_IDLE && !enableIn |=> !alarmOut) // R7
    else $error("alarm not cleared by idle enable");
  a_warm_retains: assert property (@(posedge core_clk) disable iff (porRst) rst |=> // R8
    $stable(runH_q) && $stable(remH_q) && $stable(perH_q)) else $error("retained value lost in warm reset");
  a_period_range: assert property (perH_q <= PER_H_MAX && perM_q <= MIN_MAX) // R9
    else $error("period out of range");
  a_run_saturate: assert property (live && runH_q == RUN_H_MAX && !riseClr && !runPresetWr |=> // R10
    runH_q == RUN_H_MAX) else $error("run hours left saturation");
  a_run_in_reset: assert property (tick && partialResetIn && !riseClr && runH_q != RUN_H_MAX |=> // R11
    toTot(runH_q, runM_q) == $past(toTot(runH_q, runM_q)) + TOT_W'(1)) else $error("run count stalled");
  a_period_reload: assert property (live && periodChg && !riseR && !riseClr |=> // R13
    remH_q == $past(effH) && remM_q == $past(effM)) else $error("period change not loaded");
  a_ext_hours: assert property (live && useExt_q && periodChg && !riseR && !riseClr |=> remM_q == '0 // R14
    && remH_q <= PER_H_MAX) else $error("external period not in whole hours");
  a_alarm_holds: assert property (ce && alarmOut && !clrCond |=> alarmOut) // R5
    else $error("alarm dropped without a clear condition");
  a_rem_floor: assert property (tick && remZero && !riseR && !riseClr && !periodChg && !preDone |=> remZero) // R15
    else $error("remaining time left zero while counting");
  a_run_range: assert property (runH_q <= RUN_H_MAX && runM_q <= MIN_MAX) // R10
    else $error("run time out of range");
  a_rem_range: assert property (remH_q <= PER_H_MAX && remM_q <= MIN_MAX) // R9
    else $error("remaining time out of range");

  c_alarm_rise: cover property (ce ##1 $rose(alarmOut));
  c_preset_done: cover property (preDone);
  c_full_clear: cover property (live && riseClr && alarmOut);
  c_saturated: cover property (runH_q == RUN_H_MAX && tick);
  c_ext_reload: cover property (live && useExt_q && periodChg);
endmodule

// ---- mhc_ctrl_prog.sv ----
/*
  Control program model: drives the monitored enable, partial reset and
  full clear levels of the maintenance hours counter.
  Assumes the caller invokes hold() from a process synchronised to core_clk.
*/
`timescale 1ns/1ps
module mhc_ctrl_prog (
  input wire logic core_clk,
  output logic enableIn,
  output logic partialResetIn,
  output logic fullClearIn
);
  initial begin
    enableIn = 1'b0;
    partialResetIn = 1'b0;
    fullClearIn = 1'b0;
  end

  // levels change right after an edge, then stand for n edges
  task automatic hold(input logic en, input logic pr, input logic fc, input int n);
    @(posedge core_clk);
    enableIn <= en;
    partialResetIn <= pr;
    fullClearIn <= fc;
    repeat (n) @(posedge core_clk);
  endtask
endmodule

// ---- mhc_maint_counter_tb.sv ----
/*
  Self-checking bench for the maintenance hours counter: APB register
  tasks, a control program model on the level inputs, directed scenarios.
  Assumes zero-wait APB with ce high and a four-cycle minute.
*/
`timescale 1ns/1ps
module mhc_maint_counter_tb;
  import mhc_pkg::*;
  localparam int unsigned TICKS = 4;
  logic core_clk, rst, porRst, ce, psel, penable, pwrite, pready, pslverr, alarmOut;
  logic enableIn, partialResetIn, fullClearIn;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdData, runA;
  logic [PER_HW-1:0] extPeriodHours;
  logic rdErr;
  int err_count = 0;
  int tests_run = 0;

  mhc_maint_counter #(.MINUTE_TICKS(TICKS)) dut_u (.core_clk(core_clk), .rst(rst), .porRst(porRst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enableIn(enableIn),
    .partialResetIn(partialResetIn), .fullClearIn(fullClearIn), .extPeriodHours(extPeriodHours),
    .alarmOut(alarmOut));
  mhc_ctrl_prog prog_u (.core_clk(core_clk), .enableIn(enableIn), .partialResetIn(partialResetIn),
    .fullClearIn(fullClearIn));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] hm(input int h, input int m);
    return (32'(m) << MIN_LSB) | 32'(h);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // setup then access held until pready seen high at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask

  // preset division takes a few dozen cycles
  task automatic waitIdle();
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rdData[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk({31'h0, rdData[STAT_BUSY_BIT]}, 32'h0);
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end

  initial begin
    rst = 1'b1;
    porRst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    extPeriodHours = 14'h0000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    porRst <= 1'b0;
    rdChk(OFF_CTRL, 32'h0);
    rdChk(OFF_PERIOD, 32'h0);
    rdChk(OFF_RUN, 32'h0);
    rdChk(8'h14, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    chk({31'h0, alarmOut}, 32'h1);
    apb(1'b1, OFF_PERIOD, hm(0, 3));
    rdChk(OFF_REMAIN, hm(0, 3));
    prog_u.hold(1'b0, 1'b1, 1'b0, 2);
    chk({31'h0, alarmOut}, 32'h0);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    // partial progress: lost remaining equals gained run time
    prog_u.hold(1'b1, 1'b0, 1'b0, 6);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    apb(1'b0, OFF_RUN, 32'h0);
    runA = rdData;
    chk(runA, hm(0, 1));
    rdChk(OFF_REMAIN, hm(0, 2));
    prog_u.hold(1'b1, 1'b0, 1'b0, 20);
    prog_u.hold(1'b0, 1'b0, 1'b0, 2);
    rdChk(OFF_REMAIN, 32'h0);
    chk({31'h0, alarmOut}, 32'h1);
    rdChk(OFF_STATUS, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, alarmOut}, 32'h0);
    prog_u.hold(1'b1, 1'b0, 1'b0, 3);
    chk({31'h0, alarmOut}, 32'h1);
    apb(1'b0, OFF_RUN, 32'h0);
    runA = rdData;
    prog_u.hold(1'b1, 1'b1, 1'b0, 12);
    chk({31'h0, alarmOut}, 32'h0);
    apb(1'b0, OFF_RUN, 32'h0);
    chk({31'h0, rdData > runA}, 32'h1);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    prog_u.hold(1'b0, 1'b0, 1'b1, 2);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    rdChk(OFF_RUN, 32'h0);
    rdChk(OFF_REMAIN, hm(0, 3));
    chk({31'h0, alarmOut}, 32'h0);
    // warm reset must leave retained values alone
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(OFF_PERIOD, hm(0, 3));
    rdChk(OFF_REMAIN, hm(0, 3));
    apb(1'b1, OFF_PERIOD, 32'h3f003fff);
    rdChk(OFF_PERIOD, hm(9999, 59));
    rdChk(OFF_REMAIN, hm(9999, 59));
    extPeriodHours <= 14'h00c;
    apb(1'b1, OFF_CTRL, 32'h2);
    repeat (2) @(posedge core_clk);
    rdChk(OFF_REMAIN, hm(12, 0));
    extPeriodHours <= 14'h3fff;
    repeat (2) @(posedge core_clk);
    rdChk(OFF_REMAIN, hm(9999, 0));
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b1, OFF_PERIOD, hm(30, 0));
    apb(1'b1, OFF_RUN, hm(100, 0));
    waitIdle();
    rdChk(OFF_REMAIN, hm(20, 0));
    rdChk(OFF_RUN, hm(100, 0));
    apb(1'b1, OFF_RUN, 32'h3f01ffff);
    waitIdle();
    rdChk(OFF_RUN, hm(99999, 59));
    apb(1'b1, OFF_CTRL, 32'h0);
    prog_u.hold(1'b1, 1'b0, 1'b0, 12);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    rdChk(OFF_RUN, hm(99999, 59));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rdData[STAT_SAT_BIT]}, 32'h1);
    apb(1'b1, OFF_RUN, hm(5, 0));
    rdChk(OFF_RUN, hm(99999, 59));
    // partial reset pulse with enable low: reload only, run time kept
    prog_u.hold(1'b0, 1'b1, 1'b0, 2);
    prog_u.hold(1'b0, 1'b0, 1'b0, 1);
    rdChk(OFF_RUN, hm(99999, 59));
    rdChk(OFF_REMAIN, hm(30, 0));
    results();
  end
endmodule
